// ---- rtl/eac_regs.svh ----
// Register offsets, field positions, widths and timing counts of the access controller
`ifndef EAC_REGS_SVH
`define EAC_REGS_SVH

// I/O offsets (data-space address is I/O offset plus the data-space shift)
`define EAC_OFF_SCRATCH0 6'h1e
`define EAC_OFF_CTRL 6'h1f
`define EAC_OFF_DATA 6'h20
`define EAC_OFF_ADDR_LO 6'h21
`define EAC_OFF_ADDR_HI 6'h22
`define EAC_OFF_SCRATCH1 6'h2a
`define EAC_OFF_SCRATCH2 6'h2b

// Address space limits
`define EAC_IO_TOP 8'h3f
`define EAC_BIT_TOP 8'h1f
`define EAC_DS_SHIFT 8'h20
`define EAC_EXT_BASE 8'h60

// Control register bit positions
`define EAC_BIT_READ 0
`define EAC_BIT_STROBE 1
`define EAC_BIT_ARM 2
`define EAC_BIT_IE 3

// Array geometry: largest variant, 11 address bits, 2048 bytes
`define EAC_AW 11
`define EAC_DEPTH 2048
`define EAC_AHI_W 3

// Timing in CPU clock cycles, write length in RC oscillator cycles
`define EAC_ARM_CYCLES 3'h4
`define EAC_RD_STALL 3'h4
`define EAC_WR_STALL 3'h2
`define EAC_WR_RC_CYCLES 27072
`define EAC_TW 15

// Reset values
`define EAC_SCRATCH_RST 8'h00

`endif

// ---- rtl/eac_pkg.sv ----
// Types shared by the access controller modules
`include "eac_regs.svh"
`default_nettype none
package eac_pkg;

    typedef enum logic [1:0] {
        EAC_W_IDLE = 2'b01,
        EAC_W_BUSY = 2'b10
    } eac_wstate_e;

    // Write engine state, kept alive across a system reset
    typedef struct packed {
        eac_wstate_e st;
        logic [`EAC_TW-1:0] cnt;
        logic [`EAC_AW-1:0] addr;
        logic [7:0] data;
        logic commit;
    } eac_wtimer_s;

    // CPU-facing register state
    typedef struct packed {
        logic [`EAC_AW-1:0] addr;
        logic [7:0] data;
        logic ie;
        logic arm;
        logic [2:0] arm_cnt;
        logic [2:0] stall_cnt;
        logic stall;
        logic irq;
        logic rd_pend;
        logic [7:0] rdata;
        logic [7:0] scr0;
        logic [7:0] scr1;
        logic [7:0] scr2;
    } eac_regs_s;

endpackage
`default_nettype wire

// ---- rtl/eac_mem.sv ----
// Byte-wide array storage with a registered read port
`include "eac_regs.svh"
`default_nettype none
module eac_mem import eac_pkg::*; (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [`EAC_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [`EAC_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    // Contents are nonvolatile, so no reset touches the array
    logic [7:0] mem [0:`EAC_DEPTH-1];

    // Write port and registered read port
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule
`default_nettype wire

// ---- rtl/eac_wtimer.sv ----
// Timed array write engine, counts oscillator ticks and commits one byte
`include "eac_regs.svh"
`default_nettype none
module eac_wtimer import eac_pkg::*; #(
    parameter logic [`EAC_TW-1:0] WRITE_RC_CYCLES = `EAC_TW'(`EAC_WR_RC_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic por_n,
    input wire logic start,
    input wire logic [`EAC_AW-1:0] start_addr,
    input wire logic [7:0] start_data,
    input wire logic rc_tick,
    output logic busy,
    output logic commit,
    output logic [`EAC_AW-1:0] commit_addr,
    output logic [7:0] commit_data
);

    eac_wtimer_s s_r;
    eac_wtimer_s s_nxt;

    // Idle takes a start, busy counts ticks then pulses commit
    always_comb begin
        s_nxt = s_r;
        s_nxt.commit = 1'b0;
        case (s_r.st)
            EAC_W_IDLE: begin
                if (start) begin
                    s_nxt.st = EAC_W_BUSY;
                    s_nxt.cnt = WRITE_RC_CYCLES;
                    s_nxt.addr = start_addr;
                    s_nxt.data = start_data;
                end
            end
            EAC_W_BUSY: begin
                // Ticks come from the RC oscillator, not the CPU clock
                if (rc_tick) begin
                    if (s_r.cnt == `EAC_TW'(1)) begin
                        s_nxt.st = EAC_W_IDLE;
                        s_nxt.commit = 1'b1;
                    end else begin
                        s_nxt.cnt = s_r.cnt - `EAC_TW'(1);
                    end
                end
            end
            default: begin
                s_nxt.st = EAC_W_IDLE;
            end
        endcase
    end

    // Power-on reset only: a system reset must not abort a write
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            s_r <= '{st: EAC_W_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.st == EAC_W_BUSY);
    assign commit = s_r.commit;
    assign commit_addr = s_r.addr;
    assign commit_data = s_r.data;

endmodule
`default_nettype wire

// ---- rtl/eac_top.sv ----
// CPU-side access controller for the byte-wide data array
// Overview of operation
// - A write in progress survives a system reset and completes.
// - Address selects one byte linearly; unused upper address bits read zero.
// - Bytes map linearly from zero; top address bit exists on largest array.
// - Data register holds byte to store, and byte fetched after a read.
// - Ready request forwarded only with enable bit and global interrupt enable.
// - Ready request is a level while not busy and enabled.
// - Write starts only if strobe set within four cycles of arming.
// - Arming bit clears itself four cycles after software sets it.
// - Strobe while not armed does nothing.
// - Writing read bit fetches addressed byte into the data register at once.
// - A read stalls the core four cycles.
// - Low registers reachable by I/O port access and at data address plus 0x20.
// - Registers at I/O 0x00 to 0x1F allow single-bit set, clear, test.
// - Single-bit operations change only the named bit.
// - Extended range from data address 0x60 is not decoded; accesses there miss.
// - Three scratch bytes, reset zero, plain read/write, low one bit-accessible.
// - Strobe bit reads one while writing, clears itself when done.
// - An array write lasts 27072 RC oscillator cycles.
// - While writing, reads are ignored and the address holds.
// - An accepted write strobe stalls the core two cycles.
`include "eac_regs.svh"
`default_nettype none
module eac_top import eac_pkg::*; #(
    parameter logic [`EAC_TW-1:0] WRITE_RC_CYCLES = `EAC_TW'(`EAC_WR_RC_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic por_n,
    input wire logic rc_tick,
    input wire logic io_space,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_bset,
    input wire logic io_bclr,
    input wire logic [2:0] io_bit,
    input wire logic [7:0] io_wdata,
    input wire logic global_irq_en,
    output logic [7:0] io_rdata,
    output logic cpu_stall,
    output logic ready_irq
);

    eac_regs_s r_r;
    eac_regs_s r_nxt;

    logic wr_busy;
    logic wr_commit;
    logic [`EAC_AW-1:0] wr_commit_addr;
    logic [7:0] wr_commit_data;
    logic [7:0] mem_rdata;
    logic wr_start;
    logic rd_start;

    // Decode a bus address into an I/O offset; bit 6 of the result is the hit
    function automatic logic [6:0] eac_decode(input logic space, input logic [7:0] a);
        logic [7:0] off;
        off = 8'h00;
        if (space) begin
            // Port instructions reach only the low 64 locations
            if (a <= `EAC_IO_TOP) begin
                return {1'b1, a[5:0]};
            end
            return 7'h00;
        end
        // Data space sees the same registers shifted up
        if (a >= `EAC_DS_SHIFT && a < `EAC_EXT_BASE) begin
            off = a - `EAC_DS_SHIFT;
            return {1'b1, off[5:0]};
        end
        return 7'h00;
    endfunction

    // Which bits an access writes: full byte, or one bit for set and clear
    function automatic logic [7:0] eac_wmask(input logic bitop, input logic [2:0] b);
        if (bitop) begin
            return 8'h01 << b;
        end
        return 8'hff;
    endfunction

    // Merge the written bits into an old register value
    function automatic logic [7:0] eac_merge(input logic [7:0] old, input logic [7:0] m,
                                              input logic [7:0] v);
        return (old & ~m) | (v & m);
    endfunction

    logic [6:0] dec;
    logic hit;
    logic [5:0] off;
    logic bitop;
    logic bit_ok;
    logic wr_any;
    logic [7:0] wmask;
    logic [7:0] wval;
    logic [7:0] ctrl_rd;
    logic [7:0] ahi_rd;
    logic [7:0] rd_mux;
    logic [7:0] ahi_old;
    logic [7:0] ahi_new;
    logic [7:0] alo_new;

    // Address decode and write qualification
    always_comb begin
        dec = eac_decode(io_space, io_addr);
        hit = dec[6];
        off = dec[5:0];
        bitop = io_bset | io_bclr;
        // Bit instructions exist only for the low 32 I/O locations
        bit_ok = io_space && (io_addr <= `EAC_BIT_TOP);
        wr_any = hit && (io_wr || (bitop && bit_ok));
        wmask = eac_wmask(bitop, io_bit);
        wval = bitop ? (io_bset ? 8'hff : 8'h00) : io_wdata;
    end

    // Readback values; reserved bits come back as zero
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`EAC_BIT_IE] = r_r.ie;
        ctrl_rd[`EAC_BIT_ARM] = r_r.arm;
        ctrl_rd[`EAC_BIT_STROBE] = wr_busy;
        ahi_rd = {{(16-`EAC_AW){1'b0}}, r_r.addr[`EAC_AW-1:8]};
        case (off)
            `EAC_OFF_SCRATCH0: rd_mux = r_r.scr0;
            `EAC_OFF_CTRL: rd_mux = ctrl_rd;
            `EAC_OFF_DATA: rd_mux = r_r.data;
            `EAC_OFF_ADDR_LO: rd_mux = r_r.addr[7:0];
            `EAC_OFF_ADDR_HI: rd_mux = ahi_rd;
            `EAC_OFF_SCRATCH1: rd_mux = r_r.scr1;
            `EAC_OFF_SCRATCH2: rd_mux = r_r.scr2;
            default: rd_mux = 8'h00;
        endcase
    end

    // Strobe requests from the control register
    always_comb begin
        // A strobe is taken only while armed and while no write runs
        wr_start = wr_any && (off == `EAC_OFF_CTRL) && wmask[`EAC_BIT_STROBE]
            && wval[`EAC_BIT_STROBE] && r_r.arm && !wr_busy;
        // Reads are refused while the array is being written
        rd_start = wr_any && (off == `EAC_OFF_CTRL) && wmask[`EAC_BIT_READ]
            && wval[`EAC_BIT_READ] && !wr_busy;
    end

    // Register next-state logic
    always_comb begin
        r_nxt = r_r;
        ahi_old = ahi_rd;
        ahi_new = eac_merge(ahi_old, wmask, wval);
        alo_new = eac_merge(r_r.addr[7:0], wmask, wval);

        // Bus read answer, one cycle after the access
        if (hit && io_rd) begin
            r_nxt.rdata = rd_mux;
        end

        // Arming window counts down and drops the bit
        if (r_r.arm_cnt != 3'h0) begin
            r_nxt.arm_cnt = r_r.arm_cnt - 3'h1;
            if (r_r.arm_cnt == 3'h1) begin
                r_nxt.arm = 1'b0;
            end
        end

        if (wr_any) begin
            case (off)
                `EAC_OFF_SCRATCH0: r_nxt.scr0 = eac_merge(r_r.scr0, wmask, wval);
                `EAC_OFF_SCRATCH1: r_nxt.scr1 = eac_merge(r_r.scr1, wmask, wval);
                `EAC_OFF_SCRATCH2: r_nxt.scr2 = eac_merge(r_r.scr2, wmask, wval);
                `EAC_OFF_DATA: r_nxt.data = eac_merge(r_r.data, wmask, wval);
                `EAC_OFF_ADDR_LO: begin
                    // Address is frozen while a write is running
                    if (!wr_busy) begin
                        r_nxt.addr[7:0] = alo_new;
                    end
                end
                `EAC_OFF_ADDR_HI: begin
                    if (!wr_busy) begin
                        r_nxt.addr[`EAC_AW-1:8] = ahi_new[`EAC_AHI_W-1:0];
                    end
                end
                `EAC_OFF_CTRL: begin
                    if (wmask[`EAC_BIT_IE]) begin
                        r_nxt.ie = wval[`EAC_BIT_IE];
                    end
                    if (wmask[`EAC_BIT_ARM]) begin
                        // Writing one restarts the window, zero drops it
                        r_nxt.arm = wval[`EAC_BIT_ARM];
                        r_nxt.arm_cnt = wval[`EAC_BIT_ARM] ? `EAC_ARM_CYCLES : 3'h0;
                    end
                    // Busy is hardware owned: a written zero never clears it
                    if (wr_start) begin
                        r_nxt.arm = 1'b0;
                        r_nxt.arm_cnt = 3'h0;
                    end
                end
                default: begin
                    r_nxt.scr0 = r_r.scr0;
                end
            endcase
        end

        // Read fetch: data lands one cycle after the array read port
        r_nxt.rd_pend = rd_start;
        if (r_r.rd_pend) begin
            r_nxt.data = mem_rdata;
        end

        // Core stall counter; the fetch finishes well inside four cycles
        if (rd_start) begin
            r_nxt.stall_cnt = `EAC_RD_STALL;
        end else if (wr_start) begin
            r_nxt.stall_cnt = `EAC_WR_STALL;
        end else if (r_r.stall_cnt != 3'h0) begin
            r_nxt.stall_cnt = r_r.stall_cnt - 3'h1;
        end
        r_nxt.stall = (r_nxt.stall_cnt != 3'h0);

        // Ready request is a level while idle and enabled
        r_nxt.irq = r_nxt.ie && global_irq_en && !wr_busy && !wr_start;
    end

    // State register on the system reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r_r <= '{scr0: `EAC_SCRATCH_RST, scr1: `EAC_SCRATCH_RST,
                     scr2: `EAC_SCRATCH_RST, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // Write engine runs on the power-on reset so it outlives a system reset
    eac_wtimer #(
        .WRITE_RC_CYCLES(WRITE_RC_CYCLES)
    ) u_wtimer (
        .sys_clk(sys_clk),
        .por_n(por_n),
        .start(wr_start),
        .start_addr(r_r.addr),
        .start_data(r_r.data),
        .rc_tick(rc_tick),
        .busy(wr_busy),
        .commit(wr_commit),
        .commit_addr(wr_commit_addr),
        .commit_data(wr_commit_data)
    );

    // Array storage; a read can share the commit cycle, since busy drops as commit pulses
    eac_mem u_mem (
        .sys_clk(sys_clk),
        .wr_en(wr_commit),
        .wr_addr(wr_commit_addr),
        .wr_data(wr_commit_data),
        .rd_en(rd_start),
        .rd_addr(r_r.addr),
        .rd_data(mem_rdata)
    );

    assign io_rdata = r_r.rdata;
    assign cpu_stall = r_r.stall;
    assign ready_irq = r_r.irq;

endmodule
`default_nettype wire

// ---- bench/eac_top_properties.sv ----
// Port-level checks of the access controller, bound to its top module
`include "eac_regs.svh"
`default_nettype none
module eac_top_properties #(
    parameter logic [`EAC_TW-1:0] WRITE_RC_CYCLES = `EAC_TW'(`EAC_WR_RC_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic por_n,
    input wire logic rc_tick,
    input wire logic io_space,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic io_bset,
    input wire logic io_bclr,
    input wire logic [2:0] io_bit,
    input wire logic [7:0] io_wdata,
    input wire logic global_irq_en,
    input wire logic [7:0] io_rdata,
    input wire logic cpu_stall,
    input wire logic ready_irq
);
    logic [3:0] arm_sh_r;
    logic ctrl_hit, ahi_hit, rd_hit, arm_wr, stb_set, rs_set;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Decode in either address form; bit ops only in the I/O form
    assign ctrl_hit = io_addr == 8'(`EAC_OFF_CTRL) + (io_space ? 8'h00 : `EAC_DS_SHIFT);
    assign ahi_hit = io_addr == 8'(`EAC_OFF_ADDR_HI) + (io_space ? 8'h00 : `EAC_DS_SHIFT);
    assign rd_hit = io_rd && (io_space ? io_addr <= `EAC_IO_TOP
        : io_addr >= `EAC_DS_SHIFT && io_addr < `EAC_EXT_BASE);
    assign stb_set = ctrl_hit && (io_wr && io_wdata[1] || io_space && io_bset && io_bit == 3'h1);
    assign rs_set = ctrl_hit && (io_wr && io_wdata[0] || io_space && io_bset && io_bit == 3'h0);
    assign arm_wr = ctrl_hit && (io_wr && io_wdata[2] && !io_wdata[1]
        || io_space && io_bset && io_bit == 3'h2);
    // Age of the last arming, one bit per cycle; empty means the window is shut
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) arm_sh_r <= 4'h0;
        else arm_sh_r <= {arm_sh_r[2:0], arm_wr};
    end
    // Ready request high means no write is running
    a_read_stall: assert property (
        rs_set && ready_irq |=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall wrong");
    a_write_stall: assert property (
        stb_set && arm_sh_r != 4'h0 && ready_irq
        |=> cpu_stall && !ready_irq ##1 cpu_stall ##1 !cpu_stall) else $error("write stall wrong");
    a_strobe_unarmed: assert property (
        stb_set && arm_sh_r == 4'h0 |=> !cpu_stall ##1 !cpu_stall) else $error("unarmed strobe");
    a_arm_expired: assert property (
        io_rd && ctrl_hit && arm_sh_r == 4'h0 |=> !io_rdata[2]) else $error("arm not cleared");
    a_ctrl_reserved: assert property (
        io_rd && ctrl_hit |=> io_rdata[7:4] == 4'h0 && !io_rdata[0]) else $error("ctrl bits");
    a_addr_reserved: assert property (
        io_rd && ahi_hit |=> io_rdata[7:3] == 5'h00) else $error("address high bits");
    a_irq_gated: assert property (
        !global_irq_en |=> !ready_irq) else $error("irq without global enable");
    a_irq_disabled: assert property (
        (ctrl_hit && io_wr && !io_wdata[3]) ##1 !(ctrl_hit && (io_wr || io_bset))
        |=> !ready_irq) else $error("irq without enable");
    a_rdata_hold: assert property (
        !rd_hit |=> $stable(io_rdata)) else $error("read data moved");
endmodule
bind eac_top eac_top_properties #(.WRITE_RC_CYCLES(WRITE_RC_CYCLES)) eac_top_properties_inst (
    .sys_clk(sys_clk), .resetn(resetn), .por_n(por_n), .rc_tick(rc_tick),
    .io_space(io_space), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_bset(io_bset), .io_bclr(io_bclr), .io_bit(io_bit), .io_wdata(io_wdata),
    .global_irq_en(global_irq_en), .io_rdata(io_rdata), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq));
`default_nettype wire

// ---- bench/eac_core_model.sv ----
// Processor core model issuing register accesses, halting while stalled
`default_nettype none
module eac_core_model (
    input wire logic sys_clk,
    input wire logic cpu_stall,
    input wire logic [7:0] io_rdata,
    output logic io_space,
    output logic [7:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic io_bset,
    output logic io_bclr,
    output logic [2:0] io_bit,
    output logic [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {io_bclr, io_bset, io_rd, io_wr} = 4'h0;
        io_space = 1'b1;
        io_addr = 8'h00;
        io_bit = 3'h0;
        io_wdata = 8'h00;
    end
    // Kind 0 write, 1 read, 2 bit set, 3 bit clear; bit number in d[2:0]
    task automatic op(input logic [1:0] k, input logic sp, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] rv);
        @(negedge sys_clk);
        while (cpu_stall === 1'b1) @(negedge sys_clk);
        io_space = sp;
        io_addr = a;
        io_wdata = d;
        io_bit = d[2:0];
        {io_bclr, io_bset, io_rd, io_wr} = 4'h1 << k;
        @(negedge sys_clk);
        rv = io_rdata;
        {io_bclr, io_bset, io_rd, io_wr} = 4'h0;
        // Released lines flip so stale values never pass for fresh ones
        io_addr = ~a;
        io_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_eeprom_access_controller.sv ----
// Self-checking bench of the access controller driven by a core model
`include "eac_regs.svh"
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_eeprom_access_controller;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTRL = 8'(`EAC_OFF_CTRL), DATA = 8'(`EAC_OFF_DATA);
    localparam logic [7:0] ALO = 8'(`EAC_OFF_ADDR_LO), AHI = 8'(`EAC_OFF_ADDR_HI);
    localparam logic [7:0] S0 = 8'(`EAC_OFF_SCRATCH0), S1 = 8'(`EAC_OFF_SCRATCH1);
    localparam logic [7:0] S2 = 8'(`EAC_OFF_SCRATCH2);
    logic sys_clk = 1'b0, resetn = 1'b0, por_n = 1'b0, rc_tick = 1'b0, gie = 1'b0;
    logic io_space, io_wr, io_rd, io_bset, io_bclr, cpu_stall, ready_irq, rd_seen = 1'b0;
    logic [7:0] io_addr, io_wdata, io_rdata, rv;
    logic [2:0] io_bit;
    logic [15:0] ev;
    logic [15:0] expq[$];
    int mismatches = 0, checked = 0, cycles = 0;
    eac_top #(.WRITE_RC_CYCLES(15'd8)) eac_top_inst (.sys_clk(sys_clk), .resetn(resetn),
        .por_n(por_n), .rc_tick(rc_tick), .io_space(io_space), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_bset(io_bset), .io_bclr(io_bclr), .io_bit(io_bit),
        .io_wdata(io_wdata), .global_irq_en(gie), .io_rdata(io_rdata),
        .cpu_stall(cpu_stall), .ready_irq(ready_irq));
    eac_core_model eac_core_model_inst (.sys_clk(sys_clk), .cpu_stall(cpu_stall),
        .io_rdata(io_rdata), .io_space(io_space), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_bset(io_bset), .io_bclr(io_bclr), .io_bit(io_bit),
        .io_wdata(io_wdata));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Oscillator ticks on an eighth of cycles, so a write outlasts the checks made during it
    always @(negedge sys_clk) begin
        rc_tick <= ($urandom % 8) == 0;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end
    // Read data settles the cycle after the strobe edge; oldest note decides
    always @(posedge sys_clk) rd_seen <= io_rd;
    always @(negedge sys_clk) begin
        if (rd_seen && expq.size() > 0) begin
            ev = expq.pop_front();
            if (ev[7:0] != 8'h00) `CHK(io_rdata & ev[7:0], ev[15:8])
        end
    end
    // Zero mask marks a poll whose value is judged by its caller
    task automatic acc(input logic [1:0] k, input logic sp, input logic [7:0] a,
            input logic [7:0] d, input logic [7:0] e = 8'h00, input logic [7:0] m = 8'h00);
        if (k == 2'd1) expq.push_back({e, m});
        eac_core_model_inst.op(k, sp, a, d, rv);
    endtask
    task automatic stall_is(input int n);
        int c;
        c = 0;
        while (cpu_stall === 1'b1 && c < 10) begin
            c++;
            @(negedge sys_clk);
        end
        `CHK(c, n)
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200; i++) begin
            acc(1, 1, CTRL, 8'h00);
            if (rv[1] === 1'b0) break;
        end
        if (i == 200) mismatches++;
    endtask
    task automatic nv_write(input logic [10:0] a, input logic [7:0] d, input int gap,
            input int st);
        acc(0, 1, ALO, a[7:0]);
        acc(0, 0, AHI + 8'h20, {5'h00, a[10:8]});
        acc(0, 1, DATA, d);
        // A gap of two arms by a single-bit set, the others by a byte write
        if (gap == 2) begin
            acc(2, 1, CTRL, 8'h02);
        end else begin
            acc(0, 1, CTRL, 8'h0c);
        end
        repeat (gap) @(negedge sys_clk);
        acc(2, 1, CTRL, 8'h01);
        stall_is(st);
    endtask
    task automatic nv_read(input logic [10:0] a, input logic [7:0] e);
        acc(0, 1, ALO, a[7:0]);
        acc(0, 1, AHI, {5'h00, a[10:8]});
        acc(0, 1, CTRL, 8'h09);
        stall_is(4);
        acc(1, 1, DATA, 8'h00, e, 8'hff);
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        logic [10:0] a;
        logic [7:0] d0;
        int g;
        void'($urandom(95));
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        por_n = 1'b1;
        gie = 1'b1;
        // Reset values, reserved bits, unmapped place
        acc(1, 1, S0, 0, 8'h00, 8'hff);
        acc(1, 0, S1 + 8'h20, 0, 8'h00, 8'hff);
        acc(1, 1, S2, 0, 8'h00, 8'hff);
        acc(0, 1, AHI, 8'hff);
        acc(1, 1, AHI, 0, 8'h07, 8'hff);
        acc(0, 1, CTRL, 8'hf8);
        acc(1, 0, CTRL + 8'h20, 0, 8'h08, 8'hff);
        acc(1, 1, 8'h30, 0, 8'h00, 8'hff);
        `CHK(ready_irq, 1'b1)
        // Scratch in both forms; bit ops only where allowed
        d0 = 8'($urandom) & 8'hfe;
        acc(0, 0, S1 + 8'h20, d0);
        acc(0, 1, S0, 8'ha5);
        acc(2, 1, S0, 8'h01);
        acc(3, 1, S0, 8'h00);
        acc(3, 0, S0 + 8'h20, 8'h07);
        acc(2, 1, S1, 8'h00);
        acc(1, 1, S0, 0, 8'ha6, 8'hff);
        acc(1, 1, S1, 0, d0, 8'hff);
        // Port form above the I/O top misses, so the last read value stays
        acc(1, 1, S2 + 8'h20, 0, d0, 8'hff);
        // Arm reads one at the fourth cycle, zero after
        acc(0, 1, CTRL, 8'h0c);
        repeat (2) @(negedge sys_clk);
        acc(1, 1, CTRL, 0, 8'h04, 8'h04);
        acc(1, 1, CTRL, 0, 8'h00, 8'h04);
        nv_write(11'h000, 8'h00, 3, 0);
        acc(1, 1, CTRL, 0, 8'h00, 8'h06);
        // Two writes to addresses differing only in the top address bit
        a = 11'($urandom) | 11'h400;
        d0 = 8'($urandom);
        for (g = 0; g < 2; g++) begin
            nv_write(a ^ (g ? 11'h400 : 11'h000), g ? ~d0 : d0, 2 * g, 2);
            acc(1, 1, CTRL, 0, 8'h0a, 8'h0e);
            `CHK(ready_irq, 1'b0)
            acc(0, 1, DATA, 8'h5a);
            acc(0, 1, ALO, ~a[7:0]);
            acc(1, 1, ALO, 0, a[7:0], 8'hff);
            acc(0, 1, CTRL, 8'h09);
            stall_is(0);
            acc(1, 1, CTRL, 0, 8'h02, 8'h02);
            wait_idle();
            `CHK(ready_irq, 1'b1)
        end
        nv_read(a, d0);
        nv_read(a ^ 11'h400, ~d0);
        // System reset mid-write lets the write finish
        nv_write(11'h123, 8'h3c, 1, 2);
        resetn = 1'b0;
        @(negedge sys_clk);
        resetn = 1'b1;
        acc(1, 1, CTRL, 0, 8'h02, 8'hff);
        wait_idle();
        nv_read(11'h123, 8'h3c);
        gie = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(ready_irq, 1'b0)
        gie = 1'b1;
        acc(0, 1, CTRL, 8'h00);
        repeat (3) @(negedge sys_clk);
        `CHK(ready_irq, 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire
